// ---- rtl/afgpw_defs.svh ----
// Constants of the audio function group power and pin verb block
`ifndef AFGPW_DEFS_SVH
`define AFGPW_DEFS_SVH
`define AFGPW_VID_W       12
`define AFGPW_PAY_W       8
`define AFGPW_WORD_W      32
`define AFGPW_NPINS       4
`define AFGPW_TAG_W       6
`define AFGPW_PS_W        3
`define AFGPW_V_GETPAR    12'hF00
`define AFGPW_P_PWRCAP    8'h0F
`define AFGPW_P_PINCNT    8'h11
`define AFGPW_P_AMPCAP    8'h12
`define AFGPW_V_GETPWR    12'hF05
`define AFGPW_V_SETPWR    12'h705
`define AFGPW_V_GETUNS    12'hF08
`define AFGPW_V_SETUNS    12'h708
`define AFGPW_V_GETDAT    12'hF15
`define AFGPW_V_SETDAT    12'h715
`define AFGPW_V_GETEN     12'hF16
`define AFGPW_V_SETEN     12'h716
`define AFGPW_V_GETDIR    12'hF17
`define AFGPW_V_SETDIR    12'h717
`define AFGPW_V_GETWK     12'hF18
`define AFGPW_V_SETWK     12'h718
`define AFGPW_V_GETUM     12'hF19
`define AFGPW_V_SETUM     12'h719
`define AFGPW_V_GRPRST    12'h7FF
`define AFGPW_PS_D0       3'h0
`define AFGPW_PS_D3       3'h3
`define AFGPW_PS_D3COLD   3'h4
`define AFGPW_UEN_BIT     7
`define AFGPW_PWRCAP      {1'h1, 1'h1, 1'h1, 24'h000000, 5'h1F}
`define AFGPW_PINCNT      {1'h1, 1'h1, 6'h00, 8'h00, 8'h00, 8'h04}
`define AFGPW_AMPCAP      {1'h1, 8'h00, 7'h02, 1'h0, 7'h7F, 1'h0, 7'h7F}
`endif

// ---- rtl/afgpw_pkg.sv ----
// Carrier types of the audio function group power and pin verb block
`include "afgpw_defs.svh"
package afgpw_pkg;
  typedef struct packed {
    logic                     valid;
    logic [`AFGPW_VID_W-1:0]  id;
    logic [`AFGPW_PAY_W-1:0]  pay;
  } afgpw_verb_t;
  typedef struct packed {
    logic                     valid;
    logic [`AFGPW_WORD_W-1:0] data;
  } afgpw_resp_t;
endpackage : afgpw_pkg

// ---- rtl/afgpw_core.sv ----
// Audio function group power state, capability and pin verb logic
`timescale 1ns/1ps
`default_nettype none
`include "afgpw_defs.svh"
// Operation
// RQ1: Power capability reports extended states, D3 clock stop, D0 to D3Cold.
// RQ2: Power capability bit 29 reads 1: D3Hot during system S3.
// RQ3: Pin count reports four bidirectional pins, no input-only or output-only.
// RQ4: Pin count bits 31 and 30 report wake and unsolicited ability.
// RQ5: Amp capability: mute, step size 02h, 7Fh steps, unity at 7Fh.
// RQ6: Host writes requested power state to bits 2:0; default 3.
// RQ7: Bits 6:4 show actual state; 3 after any reset kind.
// RQ8: Error bit 8 set when requested state cannot be entered.
// RQ9: Bit 9 shows whether bit clock may stop; 1 after reset.
// RQ10: Bit 10 set on settings reset, cleared by reading power word.
// RQ11: Bit 7 enables unsolicited; tag 5:0 goes to response bits 31:26.
// RQ12: Pin data bits carry pin values; host clears latched bit with 0. No latch here: input pins read their live level.
// RQ13: Pin enable 0 holds pin high impedance; 1 follows direction.
// RQ14: Direction 0 is input, 1 is output; input by default.
// RQ15: Wake-enabled input pin raises status change on level change.
// RQ16: Status change only while link reset asserted, wake-enabled pins only.
// RQ17: Masked input change sends unsolicited response when group enabled.
// RQ18: Two back-to-back group reset verbs make a double group reset.
// RQ19: Unexpected link reset: link reset low while clock halt flag 0.
// RQ20: Plain link reset acts as level reset while link reset low.
// RQ21: Power states coded 0 D0, 1 D1, 2 D2, 3 D3, 4 D3Cold.
// RQ22: Pin 3 unsolicited mask governs pin 3 changes.
// RQ23: Pin controls, enable and tag clear on settings resets.
module afgpw_core (
  input  wire logic                   CLK_I,
  input  wire logic                   SRST_I,
  input  wire logic                   LINK_BCLK_I,
  input  wire logic                   LINK_RST_N_I,
  input  wire afgpw_pkg::afgpw_verb_t VERB_I,
  output var  afgpw_pkg::afgpw_resp_t RESP_O,
  output var  afgpw_pkg::afgpw_resp_t UNSOL_O,
  output logic                        STATUS_REQ_O,
  input  wire logic [`AFGPW_NPINS-1:0] GPIO_I,
  output logic [`AFGPW_NPINS-1:0]      GPIO_O,
  output logic [`AFGPW_NPINS-1:0]      GPIO_OE_O
);

  localparam int NP = `AFGPW_NPINS;

  function automatic logic hit(
    input afgpw_pkg::afgpw_verb_t v,
    input logic [`AFGPW_VID_W-1:0] code
  );
    hit = v.valid && (v.id == code);
  endfunction : hit

  // Pin and link synchronisers
  logic          bclk_s1_ff;
  logic          bclk_s2_ff;
  logic          bclk_d_ff;
  logic          lrst_s1_ff;
  logic          lrst_s2_ff;
  logic [NP-1:0] gpio_s1_ff;
  logic [NP-1:0] gpio_s2_ff;
  logic [NP-1:0] gpio_d_ff;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      bclk_s1_ff <= 1'h0;
      bclk_s2_ff <= 1'h0;
      bclk_d_ff  <= 1'h0;
      lrst_s1_ff <= 1'h0;
      lrst_s2_ff <= 1'h0;
      gpio_s1_ff <= '0;
      gpio_s2_ff <= '0;
      gpio_d_ff  <= '0;
    end else begin
      bclk_s1_ff <= LINK_BCLK_I;
      bclk_s2_ff <= bclk_s1_ff;
      bclk_d_ff  <= bclk_s2_ff;
      lrst_s1_ff <= LINK_RST_N_I;
      lrst_s2_ff <= lrst_s1_ff;
      gpio_s1_ff <= GPIO_I;
      gpio_s2_ff <= gpio_s1_ff;
      gpio_d_ff  <= gpio_s2_ff;
    end
  end

  // State
  logic [`AFGPW_PS_W-1:0]  set_ff;
  logic [`AFGPW_PS_W-1:0]  act_ff;
  logic                    err_ff;
  logic                    clkok_ff;
  logic                    flag_ff;
  logic                    uen_ff;
  logic [`AFGPW_TAG_W-1:0] tag_ff;
  logic [NP-1:0]           data_ff;
  logic [NP-1:0]           en_ff;
  logic [NP-1:0]           dir_ff;
  logic [NP-1:0]           wk_ff;
  logic [NP-1:0]           um_ff;
  logic                    arm_ff;
  logic [NP-1:0]           pend_ff;
  logic                    wake_ff;

  // Verb decode
  wire [`AFGPW_PAY_W-1:0] pay    = VERB_I.pay;
  wire                    vld    = VERB_I.valid;
  wire                    get_par = hit(VERB_I, `AFGPW_V_GETPAR);
  wire                    rd_pwr = hit(VERB_I, `AFGPW_V_GETPWR);
  wire                    wr_pwr = hit(VERB_I, `AFGPW_V_SETPWR);
  wire                    wr_uns = hit(VERB_I, `AFGPW_V_SETUNS);
  wire                    wr_dat = hit(VERB_I, `AFGPW_V_SETDAT);
  wire                    wr_en  = hit(VERB_I, `AFGPW_V_SETEN);
  wire                    wr_dir = hit(VERB_I, `AFGPW_V_SETDIR);
  wire                    wr_wk  = hit(VERB_I, `AFGPW_V_SETWK);
  wire                    wr_um  = hit(VERB_I, `AFGPW_V_SETUM);
  wire                    grp_rst = hit(VERB_I, `AFGPW_V_GRPRST);
  wire [`AFGPW_PS_W-1:0]  req_ps = pay[`AFGPW_PS_W-1:0];
  wire [NP-1:0]           pay_p  = pay[NP-1:0];

  // Reset sources
  wire link_rst = ~lrst_s2_ff;
  // RQ18 double group reset
  wire dbl_rst   = grp_rst & arm_ff;
  // RQ19 unexpected link reset
  wire unexp_rst = link_rst & ~clkok_ff;
  // RQ23 settings reset group
  wire full_rst  = SRST_I | dbl_rst | unexp_rst;
  // RQ20 level link reset
  wire ps_rst    = SRST_I | dbl_rst | link_rst;

  // Power state next values
  wire [`AFGPW_PS_W-1:0] nxt_set = wr_pwr ? req_ps : set_ff;
  // RQ21 legal state codes
  wire set_ok  = set_ff <= `AFGPW_PS_D3COLD;
  wire req_bad = req_ps > `AFGPW_PS_D3COLD;
  wire [`AFGPW_PS_W-1:0] nxt_act = set_ok ? set_ff : act_ff;
  // RQ8 error on unreachable request
  wire nxt_err = wr_pwr ? req_bad : err_ff;
  // RQ9 clock halt allowed in D3 states
  wire nxt_clkok = (act_ff == `AFGPW_PS_D3) | (act_ff == `AFGPW_PS_D3COLD);
  // RQ10 cleared by power word read
  wire nxt_flag = rd_pwr ? 1'h0 : flag_ff;
  wire nxt_arm  = vld ? grp_rst & ~arm_ff : arm_ff & ~link_rst;

  // RQ6 requested state stored
  always_ff @(posedge CLK_I) begin
    // RQ7 actual state reset
    if (ps_rst) begin
      set_ff <= `AFGPW_PS_D3;
      act_ff <= `AFGPW_PS_D3;
    end else begin
      set_ff <= nxt_set;
      act_ff <= nxt_act;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      arm_ff <= 1'h0;
    end else begin
      arm_ff <= nxt_arm;
    end
  end

  // Pin modes and change detection
  // RQ14 direction zero is input
  wire [NP-1:0] in_mode = en_ff & ~dir_ff;
  wire [NP-1:0] change  = (gpio_s2_ff ^ gpio_d_ff) & in_mode;
  // RQ17 masked change with group enable
  // RQ22 each mask bit governs its own pin
  wire [NP-1:0] uns_hit = change & um_ff & {NP{uen_ff}};
  wire          bclk_rise = bclk_s2_ff & ~bclk_d_ff;
  wire          send    = bclk_rise & ~link_rst & (pend_ff != '0);
  wire [NP-1:0] nxt_pend = (send ? '0 : pend_ff) | uns_hit;
  // RQ15 wake on input level change
  // RQ16 only in link reset, wake-enabled pins
  wire          nxt_wake = link_rst & (wake_ff | |(change & wk_ff));
  // RQ12 data written; input pins read their level
  wire [NP-1:0] nxt_data = wr_dat ? pay_p : data_ff;
  wire [NP-1:0] dat_rd   = (dir_ff & data_ff) | (~dir_ff & gpio_s2_ff);

  always_ff @(posedge CLK_I) begin
    // RQ23 settings reset values
    if (full_rst) begin
      err_ff   <= 1'h0;
      clkok_ff <= 1'h1;
      flag_ff  <= 1'h1;
      uen_ff   <= 1'h0;
      tag_ff   <= '0;
      data_ff  <= '0;
      en_ff    <= '0;
      dir_ff   <= '0;
      wk_ff    <= '0;
      um_ff    <= '0;
    end else begin
      err_ff   <= nxt_err;
      clkok_ff <= nxt_clkok;
      flag_ff  <= nxt_flag;
      uen_ff   <= wr_uns ? pay[`AFGPW_UEN_BIT] : uen_ff;
      tag_ff   <= wr_uns ? pay[`AFGPW_TAG_W-1:0] : tag_ff;
      data_ff  <= nxt_data;
      en_ff    <= wr_en ? pay_p : en_ff;
      dir_ff   <= wr_dir ? pay_p : dir_ff;
      wk_ff    <= wr_wk ? pay_p : wk_ff;
      um_ff    <= wr_um ? pay_p : um_ff;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pend_ff <= '0;
      wake_ff <= 1'h0;
    end else begin
      pend_ff <= nxt_pend;
      wake_ff <= nxt_wake;
    end
  end

  // Read words
  wire [`AFGPW_WORD_W-1:0] pwr_word = {21'h000000, flag_ff, clkok_ff, err_ff,
                                       1'h0, act_ff, 1'h0, set_ff};
  wire [`AFGPW_WORD_W-1:0] uns_word = {24'h000000, uen_ff, 1'h0, tag_ff};
  wire [`AFGPW_WORD_W-1:0] par_word =
    // RQ1 RQ2 power capability
    (pay == `AFGPW_P_PWRCAP) ? `AFGPW_PWRCAP :
    // RQ3 RQ4 pin count
    (pay == `AFGPW_P_PINCNT) ? `AFGPW_PINCNT :
    // RQ5 amplifier capability
    (pay == `AFGPW_P_AMPCAP) ? `AFGPW_AMPCAP : '0;
  wire [`AFGPW_WORD_W-1:0] rd_word =
    get_par ? par_word :
    rd_pwr ? pwr_word :
    hit(VERB_I, `AFGPW_V_GETUNS) ? uns_word :
    hit(VERB_I, `AFGPW_V_GETDAT) ? {28'h0000000, dat_rd} :
    hit(VERB_I, `AFGPW_V_GETEN) ? {28'h0000000, en_ff} :
    hit(VERB_I, `AFGPW_V_GETDIR) ? {28'h0000000, dir_ff} :
    hit(VERB_I, `AFGPW_V_GETWK) ? {28'h0000000, wk_ff} :
    hit(VERB_I, `AFGPW_V_GETUM) ? {28'h0000000, um_ff} : '0;
  // RQ11 tag in response bits 31:26
  wire [`AFGPW_WORD_W-1:0] uns_msg = {tag_ff, 22'h000000, pend_ff};

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      RESP_O  <= '0;
      UNSOL_O <= '0;
    end else begin
      RESP_O.valid  <= vld;
      RESP_O.data   <= rd_word;
      UNSOL_O.valid <= send;
      UNSOL_O.data  <= send ? uns_msg : UNSOL_O.data;
    end
  end

  // Pin drivers
  // RQ13 disabled pin floats
  assign GPIO_OE_O    = en_ff & dir_ff;
  assign GPIO_O       = data_ff;
  assign STATUS_REQ_O = wake_ff;

  // Checks
  chk_pwrcap_word: assert property (  // RQ1
    @(posedge CLK_I) disable iff (SRST_I)
    get_par && pay == `AFGPW_P_PWRCAP |=> RESP_O.valid && RESP_O.data[31:29] == 3'h7)
    else $error("power capability word wrong");
  chk_pincnt_word: assert property (  // RQ3
    @(posedge CLK_I) disable iff (SRST_I)
    get_par && pay == `AFGPW_P_PINCNT |=> RESP_O.data == `AFGPW_PINCNT)
    else $error("pin count word wrong");
  chk_ampcap_word: assert property (  // RQ5
    @(posedge CLK_I) disable iff (SRST_I)
    get_par && pay == `AFGPW_P_AMPCAP |=> RESP_O.data == `AFGPW_AMPCAP)
    else $error("amp capability word wrong");
  chk_act_linkrst: assert property (  // RQ7
    @(posedge CLK_I) disable iff (SRST_I)
    link_rst |=> act_ff == `AFGPW_PS_D3 && set_ff == `AFGPW_PS_D3)
    else $error("actual state not reset by link reset");
  chk_err_request: assert property (  // RQ8
    @(posedge CLK_I) disable iff (SRST_I)
    wr_pwr && !full_rst |=> err_ff == $past(req_bad) ##1 act_ff == $past(act_ff)
      || !$past(req_bad, 2))
    else $error("error flag or state wrong after request");
  chk_flag_clear: assert property (  // RQ10
    @(posedge CLK_I) disable iff (SRST_I)
    rd_pwr && !full_rst |=> !flag_ff ##1 RESP_O.data[10] == 1'h0 || !RESP_O.valid)
    else $error("settings flag not cleared by read");
  chk_pin_hiz: assert property (  // RQ13
    @(posedge CLK_I) disable iff (SRST_I)
    wr_en && !full_rst |=> (GPIO_OE_O & ~$past(pay_p)) == '0)
    else $error("disabled pin still driven");
  chk_wake_gate: assert property (  // RQ16
    @(posedge CLK_I) disable iff (SRST_I)
    $rose(STATUS_REQ_O) |-> $past(link_rst) && $past(|(change & wk_ff)))
    else $error("status change outside link reset");
  chk_unsol_tag: assert property (  // RQ11
    @(posedge CLK_I) disable iff (SRST_I)
    UNSOL_O.valid |-> UNSOL_O.data[31:26] == $past(tag_ff) && $past(bclk_rise))
    else $error("unsolicited tag or timing wrong");
  chk_set_store: assert property (  // RQ6
    @(posedge CLK_I) disable iff (SRST_I)
    wr_pwr && !ps_rst |=> set_ff == $past(req_ps))
    else $error("requested state not stored");
  chk_act_illegal: assert property (  // RQ21
    @(posedge CLK_I) disable iff (SRST_I)
    !ps_rst && set_ff > `AFGPW_PS_D3COLD |=> $stable(act_ff))
    else $error("actual state followed an illegal code");
  chk_clkok_state: assert property (  // RQ9
    @(posedge CLK_I) disable iff (SRST_I)
    !full_rst |=> clkok_ff == ($past(act_ff) >= `AFGPW_PS_D3))
    else $error("clock halt flag wrong for state");
  chk_flag_set: assert property (  // RQ10
    @(posedge CLK_I) disable iff (SRST_I)
    full_rst |=> flag_ff)
    else $error("settings flag not set by reset");
  chk_uns_store: assert property (  // RQ11
    @(posedge CLK_I) disable iff (SRST_I)
    wr_uns && !full_rst |=> uen_ff == $past(pay[`AFGPW_UEN_BIT])
      && tag_ff == $past(pay[`AFGPW_TAG_W-1:0]))
    else $error("unsolicited control not stored");
  chk_data_out: assert property (  // RQ12
    @(posedge CLK_I) disable iff (SRST_I)
    wr_dat && !full_rst |=> GPIO_O == $past(pay_p))
    else $error("pin data not driven");
  chk_en_store: assert property (  // RQ13
    @(posedge CLK_I) disable iff (SRST_I)
    wr_en && !full_rst |=> en_ff == $past(pay_p))
    else $error("pin enable not stored");
  chk_dir_input: assert property (  // RQ14
    @(posedge CLK_I) disable iff (SRST_I)
    wr_dir && !full_rst |=> (GPIO_OE_O & ~$past(pay_p)) == '0)
    else $error("input pin driven");
  chk_reset_pins: assert property (  // RQ23
    @(posedge CLK_I) disable iff (SRST_I)
    full_rst |=> GPIO_OE_O == '0 && GPIO_O == '0)
    else $error("pins not cleared by settings reset");
  chk_wake_hold: assert property (  // RQ16
    @(posedge CLK_I) disable iff (SRST_I)
    !link_rst |=> !STATUS_REQ_O)
    else $error("status change outside link reset");
  chk_pend_latch: assert property (  // RQ17
    @(posedge CLK_I) disable iff (SRST_I)
    uns_hit != '0 |=> (pend_ff & $past(uns_hit)) == $past(uns_hit))
    else $error("masked pin change not latched");
  chk_pend_send: assert property (  // RQ17
    @(posedge CLK_I) disable iff (SRST_I)
    send |=> UNSOL_O.valid && UNSOL_O.data[NP-1:0] == $past(pend_ff))
    else $error("pending changes not sent");
  chk_dbl_reset: assert property (  // RQ18
    @(posedge CLK_I) disable iff (SRST_I)
    dbl_rst |=> en_ff == '0 && act_ff == `AFGPW_PS_D3 && flag_ff)
    else $error("double group reset incomplete");
  chk_arm_clear: assert property (  // RQ18
    @(posedge CLK_I) disable iff (SRST_I)
    vld && !grp_rst |=> !arm_ff)
    else $error("group reset armed across other verb");
  chk_unexp_reset: assert property (  // RQ19
    @(posedge CLK_I) disable iff (SRST_I)
    unexp_rst |=> !uen_ff && clkok_ff)
    else $error("unexpected link reset incomplete");

endmodule : afgpw_core
`default_nettype wire

// ---- test/afgpw_host.sv ----
// Host link controller model: bit clock, link reset, verb issue, unsolicited capture
`timescale 1ns/1ps
`default_nettype none
`include "afgpw_defs.svh"
module afgpw_host (
  input  wire logic                   clk_i,
  input  wire afgpw_pkg::afgpw_resp_t resp_i,
  input  wire afgpw_pkg::afgpw_resp_t unsol_i,
  output logic                        bclk_o,
  output logic                        link_rst_n_o,
  output afgpw_pkg::afgpw_verb_t      verb_o
);
  int                        unsol_cnt;
  int                        late_cnt;
  logic [`AFGPW_WORD_W-1:0]  unsol_last;
  initial begin
    bclk_o = 1'b0;
    link_rst_n_o = 1'b1;
    verb_o = '0;
    unsol_cnt = 0;
    late_cnt = 0;
    unsol_last = '0;
  end
  // Free running bit clock, 200 ns period
  always #100 bclk_o = ~bclk_o;
  // Sample away from the launching edge
  always @(negedge clk_i) begin
    if (unsol_i.valid === 1'b1) begin
      unsol_cnt++;
      unsol_last = unsol_i.data;
    end
  end
  // one verb per call, valid for one clock, answer awaited up to 4 clocks
  task automatic xfer(input logic [11:0] id, input logic [7:0] pay, output logic [31:0] rd);
    int n;
    n = 0;
    @(negedge clk_i);
    verb_o = {1'b1, id, pay};
    @(negedge clk_i);
    verb_o.valid = 1'b0;
    while (resp_i.valid !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    if (resp_i.valid !== 1'b1) begin
      late_cnt++;
    end
    rd = resp_i.data;
  endtask : xfer
endmodule : afgpw_host
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench of the function group power and pin verb block
`timescale 1ns/1ps
`default_nettype none
`include "afgpw_defs.svh"
`define TB_CMP(g, e, m) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e); end end
module tb;
  logic                   clk;
  logic                   srst;
  logic [3:0]             gpio_in;
  logic [3:0]             gpio_out;
  logic [3:0]             gpio_oe;
  logic                   bclk;
  logic                   link_rst_n;
  logic                   status_req;
  afgpw_pkg::afgpw_verb_t verb;
  afgpw_pkg::afgpw_resp_t resp;
  afgpw_pkg::afgpw_resp_t unsol;
  logic [31:0]            rd;
  logic [3:0]             en;
  logic [3:0]             dir;
  logic [3:0]             dat;
  logic [3:0]             wk;
  logic [2:0]             act;
  int                     mismatches;
  int                     samples_checked;
  int                     cnt;
  int                     n;

  afgpw_core dut_u (
    .CLK_I(clk), .SRST_I(srst), .LINK_BCLK_I(bclk), .LINK_RST_N_I(link_rst_n),
    .VERB_I(verb), .RESP_O(resp), .UNSOL_O(unsol), .STATUS_REQ_O(status_req),
    .GPIO_I(gpio_in), .GPIO_O(gpio_out), .GPIO_OE_O(gpio_oe)
  );
  afgpw_host host_u (
    .clk_i(clk), .resp_i(resp), .unsol_i(unsol),
    .bclk_o(bclk), .link_rst_n_o(link_rst_n), .verb_o(verb)
  );

  function automatic logic [31:0] pw_exp(input logic [2:0] s, input logic [2:0] a);
    return {22'h0, (a >= 3'h3), (s > 3'h4), 1'b0, a, 1'b0, s};
  endfunction : pw_exp

  task automatic chk(input logic [11:0] id, input logic [7:0] pay, input logic [31:0] e,
                     input string m);
    host_u.xfer(id, pay, rd);
    `TB_CMP(rd, e, m)
  endtask : chk

  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask : wt

  task automatic test_done;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  always #12.5 clk = ~clk;

  initial begin
    #2ms;
    mismatches++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    gpio_in = 4'h0;
    mismatches = 0;
    samples_checked = 0;
    act = 3'h3;
    n = $urandom(21);
    wt(4);
    srst = 1'b0;
    wt(3);
    chk(12'hF05, 8'h00, 32'h0000_0633, "pwr rst");
    chk(12'hF05, 8'h00, 32'h0000_0233, "pwr flag");
    chk(12'hF00, 8'h0F, 32'hE000_001F, "pwrcap");
    chk(12'hF00, 8'h11, 32'hC000_0004, "pincnt");
    chk(12'hF00, 8'h12, 32'h8002_7F7F, "ampcap");
    for (int i = 0; i < 6; i++) begin
      chk((i == 0) ? 12'hF08 : 12'hF15 + 12'(i - 1), 8'h00, 32'h0, "dflt");
    end
    for (int s = 0; s < 8; s++) begin
      chk(12'h705, 8'(s), 32'h0, "pwr set");
      wt(4);
      act = (s <= 4) ? 3'(s) : act;
      chk(12'hF05, 8'h00, pw_exp(3'(s), act), "pwr word");
    end
    repeat (8) begin
      en = 4'($urandom);
      dir = 4'($urandom);
      dat = 4'($urandom);
      wk = 4'($urandom);
      gpio_in = 4'($urandom);
      chk(12'h716, {4'h0, en}, 32'h0, "en wr");
      chk(12'h717, {4'h0, dir}, 32'h0, "dir wr");
      chk(12'h715, {4'h0, dat}, 32'h0, "dat wr");
      wt(3);
      `TB_CMP(gpio_oe, en & dir, "oe")
      `TB_CMP(gpio_out, dat, "out")
      chk(12'hF16, 8'h00, {28'h0, en}, "en rd");
      chk(12'hF17, 8'h00, {28'h0, dir}, "dir rd");
      chk(12'h716, 8'h0F, 32'h0, "en all");
      chk(12'hF15, 8'h00, {28'h0, (dir & dat) | (~dir & gpio_in)}, "dat rd");
      chk(12'h718, {4'h0, wk}, 32'h0, "wk wr");
      chk(12'hF18, 8'h00, {28'h0, wk}, "wk rd");
      chk(12'h719, {4'h0, ~wk}, 32'h0, "um wr");
      chk(12'hF19, 8'h00, {28'h0, ~wk}, "um rd");
    end
    chk(12'h717, 8'h00, 32'h0, "dir in");
    chk(12'h718, 8'h00, 32'h0, "wk off");
    chk(12'h719, 8'h09, 32'h0, "um 9");
    chk(12'h708, 8'hAD, 32'h0, "uns en");
    chk(12'hF08, 8'h00, 32'h0000_00AD, "uns rd");
    wt(60);
    cnt = host_u.unsol_cnt;
    gpio_in = gpio_in ^ 4'h6;
    wt(60);
    `TB_CMP(host_u.unsol_cnt, cnt, "unmasked")
    gpio_in = gpio_in ^ 4'h8;
    n = 0;
    while (host_u.unsol_cnt == cnt && n < 60) begin
      @(negedge clk);
      n++;
    end
    `TB_CMP(host_u.unsol_cnt, cnt + 1, "unsol")
    `TB_CMP(host_u.unsol_last, {6'h2D, 22'h0, 4'h8}, "unsol data")
    chk(12'h708, 8'h2D, 32'h0, "uns dis");
    gpio_in = gpio_in ^ 4'h1;
    wt(60);
    `TB_CMP(host_u.unsol_cnt, cnt + 1, "uns off")
    chk(12'h705, 8'h04, 32'h0, "d3cold");
    chk(12'h718, 8'h04, 32'h0, "wk 2");
    wt(4);
    link_rst_n = 1'b0;
    wt(4);
    gpio_in = gpio_in ^ 4'h2;
    wt(12);
    `TB_CMP(status_req, 1'b0, "wake off")
    gpio_in = gpio_in ^ 4'h4;
    wt(8);
    `TB_CMP(status_req, 1'b1, "wake")
    link_rst_n = 1'b1;
    wt(5);
    `TB_CMP(status_req, 1'b0, "wake end")
    host_u.xfer(12'hF05, 8'h00, rd);
    chk(12'hF05, 8'h00, pw_exp(3'h3, 3'h3), "lr pwr");
    chk(12'hF16, 8'h00, 32'h0000_000F, "lr keep");
    chk(12'h705, 8'h00, 32'h0, "d0");
    wt(4);
    link_rst_n = 1'b0;
    wt(5);
    link_rst_n = 1'b1;
    wt(4);
    chk(12'hF16, 8'h00, 32'h0, "ulr en");
    chk(12'hF08, 8'h00, 32'h0, "ulr uns");
    chk(12'hF05, 8'h00, 32'h0000_0633, "ulr pwr");
    chk(12'h716, 8'h0F, 32'h0, "en set");
    chk(12'h7FF, 8'h00, 32'h0, "grp rst");
    chk(12'hF16, 8'h00, 32'h0000_000F, "single");
    chk(12'h7FF, 8'h00, 32'h0, "grp rst");
    chk(12'h7FF, 8'h00, 32'h0, "grp rst");
    wt(2);
    chk(12'hF16, 8'h00, 32'h0, "dbl en");
    chk(12'hF05, 8'h00, 32'h0000_0633, "dbl pwr");
    chk(12'h716, 8'h0F, 32'h0, "en pre");
    srst = 1'b1;
    wt(2);
    srst = 1'b0;
    wt(3);
    `TB_CMP(gpio_oe, 4'h0, "por oe")
    chk(12'hF16, 8'h00, 32'h0, "por en");
    chk(12'hF05, 8'h00, 32'h0000_0633, "por pwr");
    `TB_CMP(host_u.late_cnt, 0, "late answers")
    test_done();
  end
endmodule : tb
`default_nettype wire
